// [core/pin_mux.sv]
// Purpose: output priority and alternate pin routing for six pins
// Assumes: peripheral enables and data come from on-chip logic
// Notes:   purely combinational
`timescale 1ns/1ns
`include "port_a_value_cfg.svh"
module pin_mux (
    input  wire logic [7:0] i_altsel,
    input  wire logic [5:0] i_dir,
    input  wire logic [5:0] i_latch,
    input  wire logic       i_wave_a,
    input  wire logic       i_wave_a_en,
    input  wire logic       i_wave_b,
    input  wire logic       i_wave_b_en,
    input  wire logic       i_logic_cell,
    input  wire logic       i_logic_cell_en,
    input  wire logic       i_osc_periph,
    input  wire logic       i_osc_periph_en,
    output logic      [5:0] o_out,
    output logic      [5:0] o_oe
);
    logic [5:0] per_en;
    logic [5:0] per_val;

    // per-pin peripheral claim, highest priority checked first
    always_comb begin
        per_en  = 6'h00;
        per_val = 6'h00;
        // position 0: wave B when not moved
        if (i_wave_b_en && !i_altsel[`SEL_WAVE_B]) begin // R12 R20
            per_en[0]  = 1'b1;
            per_val[0] = i_wave_b;
        end
        // position 1: oscillator output when not moved
        if (i_osc_periph_en && !i_altsel[`SEL_OSC_PERIPH]) begin // R16
            per_en[1]  = 1'b1;
            per_val[1] = i_osc_periph;
        end
        // position 2: wave A above logic cell
        if (i_wave_a_en && !i_altsel[`SEL_WAVE_A]) begin // R13 R20
            per_en[2]  = 1'b1;
            per_val[2] = i_wave_a;
        end else if (i_logic_cell_en && !i_altsel[`SEL_LOGIC_CELL]) begin
            per_en[2]  = 1'b1; // R15
            per_val[2] = i_logic_cell;
        end
        // position 4: wave B above logic cell
        if (i_wave_b_en && i_altsel[`SEL_WAVE_B]) begin // R12 R20
            per_en[4]  = 1'b1;
            per_val[4] = i_wave_b;
        end else if (i_logic_cell_en && i_altsel[`SEL_LOGIC_CELL]) begin
            per_en[4]  = 1'b1; // R15
            per_val[4] = i_logic_cell;
        end
        // position 5: wave A above oscillator output
        if (i_wave_a_en && i_altsel[`SEL_WAVE_A]) begin // R13 R20
            per_en[5]  = 1'b1;
            per_val[5] = i_wave_a;
        end else if (i_osc_periph_en && i_altsel[`SEL_OSC_PERIPH]) begin
            per_en[5]  = 1'b1; // R16
            per_val[5] = i_osc_periph;
        end
    end

    // driver follows direction, position 3 always off; analog select plays no part
    always_comb begin
        o_oe  = ~i_dir; // R1 R10 R19 R17
        o_oe[`PORT_INPUT_ONLY] = 1'b0; // R8
        o_out = (per_en & per_val) | (~per_en & i_latch); // R6 R1
    end
endmodule : pin_mux

// [core/pin_sync.sv]
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to I_CLOCK
// Notes:   a rise counts once stages two and three agree high; a fall counts as soon as they disagree
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // shift chain; level ORs in stage two where stages two and three agree and clears where they disagree
    always_comb begin
        next_st = st;
        next_st.s1 = i_async;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.level = (st.level & ~(st.s2 ^ st.s3))
                      | (st.s2 & ~(st.s2 ^ st.s3));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
endmodule : pin_sync

// [core/port_a_value_cfg.svh]
// Purpose: offsets, field positions, reset values for the pin port block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   included by the port modules and the bench
//
// Contract
// R1 - direction bit 1 turns the driver off; 0 drives the latch value
// R2 - writes to latch register and pin value register both update latch
// R3 - latch register reads latch; pin value register reads sampled pins
// R4 - analog select set disables that pin's digital input buffer
// R5 - analog pins read as zero in the pin value register
// R6 - enabled peripheral output overrides latch; pin still readable
// R7 - six pin positions, each with direction, latch and value bits
// R8 - position 3 is input only; its direction bit always reads one
// R9 - pin value register write merges pin levels, stores into latch; code masks pin levels off and stores written bits only
// R10 - direction bits steer drivers even while analog is selected
// R11 - software keeps analog pins set as inputs
// R12 - select bit 7 puts wave output B on position 4, else 0
// R13 - select bit 6 puts wave output A on position 5, else 2
// R14 - select bit 3 takes timer gate from position 3, else 4
// R15 - select bit 1 puts logic cell output on position 4, else 2
// R16 - select bit 0 puts oscillator output on position 5, else 1
// R17 - select bits never change direction; overrides follow chosen pin
// R18 - analog select bits reset to analog mode
// R19 - analog select never affects digital output functions
// R20 - highest priority peripheral wins a pin with several outputs
// R21 - register writes take effect at the next clock edge
`ifndef PORT_A_VALUE_CFG_SVH
`define PORT_A_VALUE_CFG_SVH

`define PORT_OFS_VALUE    12'h000
`define PORT_OFS_DIR      12'h004
`define PORT_OFS_LATCH    12'h008
`define PORT_OFS_ANALOG   12'h00C
`define PORT_OFS_ALTSEL   12'h010

`define PORT_DIR_RST      6'h3F
`define PORT_LATCH_RST    6'h00
`define PORT_ANALOG_RST   6'h3F
`define PORT_ALTSEL_RST   8'h00
`define PORT_ALTSEL_MASK  8'hCB

`define PORT_INPUT_ONLY   3
`define SEL_WAVE_B        7
`define SEL_WAVE_A        6
`define SEL_TIMER_GATE    3
`define SEL_LOGIC_CELL    1
`define SEL_OSC_PERIPH    0

`endif

// [core/port_a_value_pkg.sv]
// Purpose: shared types of the pin port block
// Assumes: six pin positions
// Notes:   constants live in port_a_value_cfg.svh
package port_a_value_pkg;
    typedef logic [5:0] pins_t;
    typedef logic [7:0] sel_t;
endpackage : port_a_value_pkg

// [core/port_a_value_top.sv]
// Purpose: six-pin general purpose port with APB register access
// Assumes: APB slave, zero wait states, 250 MHz I_CLOCK
// Notes:   pins arrive asynchronously and pass a three-stage synchroniser
`timescale 1ns/1ns
`include "port_a_value_cfg.svh"
module port_a_value_top (
    input  wire logic        I_CLOCK,
    input  wire logic        I_SYS_RST,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [5:0]  i_pin,
    output logic      [5:0]  o_pin,
    output logic      [5:0]  o_pin_oe,
    input  wire logic        i_wave_a,
    input  wire logic        i_wave_a_en,
    input  wire logic        i_wave_b,
    input  wire logic        i_wave_b_en,
    input  wire logic        i_logic_cell,
    input  wire logic        i_logic_cell_en,
    input  wire logic        i_osc_periph,
    input  wire logic        i_osc_periph_en,
    output logic             o_timer_gate_input,
    output logic      [5:0]  o_digital_in
);
    typedef struct packed {
        port_a_value_pkg::pins_t dir; // R7
        port_a_value_pkg::pins_t latch;
        port_a_value_pkg::pins_t analog;
        port_a_value_pkg::sel_t  altsel;
        logic [31:0]      rdata;
        logic             slverr;
    } port_s;

    port_s st;
    port_s next_st;

    port_a_value_pkg::pins_t pin_level;
    port_a_value_pkg::pins_t pin_read;
    port_a_value_pkg::pins_t dir_view;
    logic             wr_acc;
    logic             rd_acc;
    logic             hit;

    // pin inputs cross into the clock domain
    pin_sync #(
        .WIDTH   (6)
    ) u_sync (
        .clk     (I_CLOCK),
        .rst     (I_SYS_RST),
        .i_async (i_pin),
        .o_level (pin_level)
    );

    // output steering and driver enables
    pin_mux u_mux (
        .i_altsel        (st.altsel),
        .i_dir           (dir_view),
        .i_latch         (st.latch),
        .i_wave_a        (i_wave_a),
        .i_wave_a_en     (i_wave_a_en),
        .i_wave_b        (i_wave_b),
        .i_wave_b_en     (i_wave_b_en),
        .i_logic_cell    (i_logic_cell),
        .i_logic_cell_en (i_logic_cell_en),
        .i_osc_periph    (i_osc_periph),
        .i_osc_periph_en (i_osc_periph_en),
        .o_out           (o_pin),
        .o_oe            (o_pin_oe)
    );

    // digital input buffer, blocked where analog is selected
    always_comb begin
        pin_read = pin_level & ~st.analog; // R4 R5 R6
        dir_view = st.dir;
        dir_view[`PORT_INPUT_ONLY] = 1'b1; // R8
    end

    // decode of write access phase, read setup phase and address hit
    always_comb begin
        wr_acc = i_psel && i_penable && i_pwrite;
        rd_acc = i_psel && !i_penable && !i_pwrite;
        hit = (i_paddr == `PORT_OFS_VALUE) || (i_paddr == `PORT_OFS_DIR)
            || (i_paddr == `PORT_OFS_LATCH)
            || (i_paddr == `PORT_OFS_ANALOG)
            || (i_paddr == `PORT_OFS_ALTSEL);
    end

    // register writes in access phase, read data capture in setup phase
    always_comb begin
        next_st = st;
        if (wr_acc) begin
            if (i_paddr == `PORT_OFS_VALUE) begin
                // pin bits masked to zero; only the six written bits land in latch
                next_st.latch = (pin_read & 6'h00) | i_pwdata[5:0]; // R9 R2
            end else if (i_paddr == `PORT_OFS_LATCH) begin
                next_st.latch = i_pwdata[5:0]; // R2 R21
            end else if (i_paddr == `PORT_OFS_DIR) begin
                next_st.dir = i_pwdata[5:0]; // R21
            end else if (i_paddr == `PORT_OFS_ANALOG) begin
                next_st.analog = i_pwdata[5:0];
            end else if (i_paddr == `PORT_OFS_ALTSEL) begin
                next_st.altsel = i_pwdata[7:0] & `PORT_ALTSEL_MASK; // R17
            end
        end
        if (i_psel && !i_penable) begin
            next_st.slverr = !hit;
        end
        if (rd_acc) begin
            next_st.rdata = 32'h0000_0000;
            if (i_paddr == `PORT_OFS_VALUE) begin
                next_st.rdata[5:0] = pin_read; // R3 R5
            end else if (i_paddr == `PORT_OFS_DIR) begin
                next_st.rdata[5:0] = dir_view; // R8
            end else if (i_paddr == `PORT_OFS_LATCH) begin
                next_st.rdata[5:0] = st.latch; // R3
            end else if (i_paddr == `PORT_OFS_ANALOG) begin
                next_st.rdata[5:0] = st.analog;
            end else if (i_paddr == `PORT_OFS_ALTSEL) begin
                next_st.rdata[7:0] = st.altsel;
            end
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            st.dir    <= `PORT_DIR_RST;
            st.latch  <= `PORT_LATCH_RST;
            st.analog <= `PORT_ANALOG_RST; // R18
            st.altsel <= `PORT_ALTSEL_RST;
            st.rdata  <= 32'h0000_0000;
            st.slverr <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // answers: always ready, error flagged for unmapped offsets
    assign o_pready  = 1'b1;
    assign o_prdata  = st.rdata;
    assign o_pslverr = st.slverr && i_psel && i_penable;

    // timer gate input taken from the selected pin
    assign o_timer_gate_input = st.altsel[`SEL_TIMER_GATE] ? pin_read[3]
                                                           : pin_read[4]; // R14
    assign o_digital_in = pin_read;

    // latch register write lands on the next edge
    a_latch_write: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R21
        wr_acc && i_paddr == `PORT_OFS_LATCH |=> st.latch == $past(i_pwdata[5:0]))
        else $error("latch write did not land");
    // position 3 never driven
    a_in_only_pin: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R8
        !o_pin_oe[3])
        else $error("input only pin driven");
    // driver enable tracks direction, analog ignored
    a_dir_drive: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R1
        o_pin_oe[0] == !st.dir[0])
        else $error("driver does not follow direction");
    // analog pins read zero
    a_analog_zero: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R5
        rd_acc && i_paddr == `PORT_OFS_VALUE && st.analog[1]
        |=> !o_prdata[1])
        else $error("analog pin read as one");
    // direction read shows bit 3 set
    a_dir_read: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R8
        rd_acc && i_paddr == `PORT_OFS_DIR |=> o_prdata[3])
        else $error("direction bit 3 read as zero");
    // select write leaves direction alone
    a_sel_keep_dir: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R17
        wr_acc && i_paddr == `PORT_OFS_ALTSEL |=> $stable(st.dir))
        else $error("select write changed direction");
    // value write updates latch like latch write
    a_value_write: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R2
        wr_acc && i_paddr == `PORT_OFS_VALUE |=> st.latch == $past(i_pwdata[5:0]))
        else $error("value write did not reach latch");
    // peripheral wins over latch on position 1
    a_osc_override: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R16
        i_osc_periph_en && !st.altsel[0] |-> o_pin[1] == i_osc_periph)
        else $error("oscillator output not on position 1");
    // timer gate from position 4 when select clear
    a_gate_route: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST) // R14
        !st.altsel[3] |-> o_timer_gate_input == pin_read[4])
        else $error("timer gate from wrong pin");
endmodule : port_a_value_top

// [sim/pin_world.sv]
// Purpose: external circuitry attached to the six port pins
// Assumes: no pull resistors on the lines
// Notes:   floating lines toggle each cycle so stale levels never pass
`timescale 1ns/1ns
module pin_world (
    input  wire logic       clk,
    input  wire logic [5:0] i_out,
    input  wire logic [5:0] i_oe,
    input  wire logic [5:0] i_ext_val,
    input  wire logic [5:0] i_ext_en,
    output logic      [5:0] o_level
);
    logic [5:0] float_pat = 6'h15;

    // undriven lines show a changing pattern
    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    // device driver first, then the external source, else floating
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (i_oe[i]) begin
                o_level[i] = i_out[i];
            end else if (i_ext_en[i]) begin
                o_level[i] = i_ext_val[i];
            end else begin
                o_level[i] = float_pat[i];
            end
        end
    end
endmodule : pin_world

// [sim/port_pins_with_alt_select_bench.sv]
// Purpose: register and pin level checks of the six-pin port
// Assumes: zero wait APB slave, pins pass a three-stage synchroniser
// Notes:   expected values come from the register map and routing table
`timescale 1ns/1ns
`include "port_a_value_cfg.svh"
module port_pins_with_alt_select_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  pin_in;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe;
    logic [5:0]  dig_in;
    logic [5:0]  ext_val = 6'h00;
    logic [5:0]  ext_en = 6'h00;
    logic [3:0]  p_val = 4'h0;
    logic [3:0]  p_en = 4'h0;
    logic        gate;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          total_checks = 0;
    // sel, enables, values, expected pins; bits are A, B, cell, osc
    logic [21:0] cases [9] = '{22'h200890, 22'h000881, 22'h100460,
        22'h000444, 22'h009110, 22'h001104, 22'h006220, 22'h002202,
        22'h001444};

    // 250 MHz clock
    always #2 clk = ~clk;

    port_a_value_top u_port_a_value_top (.I_CLOCK(clk), .I_SYS_RST(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_pin(pin_in), .o_pin(pin_out),
        .o_pin_oe(pin_oe), .i_wave_a(p_val[0]), .i_wave_a_en(p_en[0]),
        .i_wave_b(p_val[1]), .i_wave_b_en(p_en[1]),
        .i_logic_cell(p_val[2]), .i_logic_cell_en(p_en[2]),
        .i_osc_periph(p_val[3]), .i_osc_periph_en(p_en[3]),
        .o_timer_gate_input(gate), .o_digital_in(dig_in));

    pin_world u_pin_world (.clk(clk), .i_out(pin_out), .i_oe(pin_oe),
        .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(pin_in));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one APB transfer, held until pready is seen high
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 16) begin
                num_errors++;
                wrap_up();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rd_chk

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk("dir", `PORT_OFS_DIR, 32'h3F);
        rd_chk("latch", `PORT_OFS_LATCH, 32'h00);
        rd_chk("analog", `PORT_OFS_ANALOG, 32'h3F);
        rd_chk("altsel", `PORT_OFS_ALTSEL, 32'h00);
        chk("oe", 32'h0, {26'h0, pin_oe});
        rd_chk("unmapped", 12'h014, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test reset done");
        xfer(1'b1, `PORT_OFS_DIR, 32'h0);
        rd_chk("dir", `PORT_OFS_DIR, 32'h08);
        @(negedge clk);
        chk("oe", 32'h37, {26'h0, pin_oe});
        xfer(1'b1, `PORT_OFS_VALUE, 32'h2A);
        rd_chk("latch", `PORT_OFS_LATCH, 32'h2A);
        @(negedge clk);
        chk("pins", 32'h22, {26'h0, pin_out & 6'h37});
        xfer(1'b1, `PORT_OFS_LATCH, 32'h15);
        rd_chk("latch", `PORT_OFS_LATCH, 32'h15);
        $display("test output done");
        xfer(1'b1, `PORT_OFS_DIR, 32'h3F);
        xfer(1'b1, `PORT_OFS_ANALOG, 32'h0);
        ext_en <= 6'h3F;
        ext_val <= 6'h2D;
        repeat (6) @(posedge clk);
        rd_chk("value", `PORT_OFS_VALUE, 32'h2D);
        chk("digital", 32'h2D, {26'h0, dig_in});
        xfer(1'b1, `PORT_OFS_ANALOG, 32'h07);
        repeat (2) @(posedge clk);
        rd_chk("value", `PORT_OFS_VALUE, 32'h28);
        chk("digital", 32'h28, {26'h0, dig_in});
        xfer(1'b1, `PORT_OFS_ANALOG, 32'h0);
        xfer(1'b1, `PORT_OFS_ALTSEL, 32'h08);
        @(negedge clk);
        chk("gate", 32'h1, {31'h0, gate});
        xfer(1'b1, `PORT_OFS_ALTSEL, 32'h00);
        @(negedge clk);
        chk("gate", 32'h0, {31'h0, gate});
        ext_en <= 6'h00;
        $display("test input done");
        xfer(1'b1, `PORT_OFS_LATCH, 32'h0);
        xfer(1'b1, `PORT_OFS_DIR, 32'h0);
        for (int i = 0; i < 9; i++) begin
            p_en <= cases[i][13:10];
            p_val <= cases[i][9:6];
            xfer(1'b1, `PORT_OFS_ALTSEL, {24'h0, cases[i][21:14]});
            @(negedge clk);
            chk("routed", {26'h0, cases[i][5:0]},
                {26'h0, pin_out & 6'h37});
        end
        // a peripheral-driven pin still reads back through the value register
        xfer(1'b0, `PORT_OFS_VALUE, 32'h0);
        chk("readback", 32'h04, rd & 32'h37);
        xfer(1'b1, `PORT_OFS_ALTSEL, 32'hFF);
        rd_chk("altsel", `PORT_OFS_ALTSEL, 32'hCB);
        rd_chk("dir", `PORT_OFS_DIR, 32'h08);
        $display("test routing done");
        // second reset in mid-run: analog select returns to analog mode
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk("analog", `PORT_OFS_ANALOG, 32'h3F);
        rd_chk("dir", `PORT_OFS_DIR, 32'h3F);
        rd_chk("altsel", `PORT_OFS_ALTSEL, 32'h00);
        $display("test second reset done");
        wrap_up();
    end
endmodule : port_pins_with_alt_select_bench
